// ==== design/bcu_top.sv ====
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
module bcu_top import bcu_pkg::*; (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [BCU_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [BCU_DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [BCU_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [BCU_DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic busy
);
  typedef struct packed {
    bcu_state_t st;
    logic aw_full;
    logic [BCU_ADDR_W-1:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rpend;
    logic [BCU_ADDR_W-1:0] araddr;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] instr;
    logic [31:0] instruction_pointer;
    logic [3:0] flags;
    logic [31:0] storage_addr;
    logic [31:0] target;
    logic long_rx;
    logic done;
    logic taken;
    logic illegal;
    logic linked;
  } bcu_regs_t;

  bcu_regs_t r;
  bcu_regs_t next_r;

  logic rf_we;
  logic [BCU_GPR_IDX_W-1:0] rf_waddr;
  logic [31:0] rf_wdata;
  logic [BCU_GPR_IDX_W-1:0] rf_raddr;
  logic [31:0] rf_rdata;
  logic dec_known;
  logic dec_hit;
  logic dec_taken;
  logic dec_link;
  logic [31:0] dec_target;
  logic [31:0] dec_next_seq;
  logic [7:0] opcode;
  logic [3:0] field_one;
  logic [3:0] field_two;
  logic aw_hs;
  logic w_hs;
  logic ar_hs;
  logic wr_fire;
  logic [31:0] status_word;

  function automatic logic is_gpr(input logic [BCU_ADDR_W-1:0] addr);
    return addr[BCU_ADDR_W-1:BCU_ADDR_W-2] == BCU_GPR_REGION;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return res;
  endfunction

  assign opcode = r.instr[BCU_INSTR_OP_LSB +: 8];
  assign field_one = r.instr[BCU_INSTR_R1_LSB +: 4];
  assign field_two = r.instr[BCU_INSTR_R2_LSB +: 4];

  // The bus is held off while a branch executes so that the register file has one user.
  assign busy = (r.st != BCU_IDLE);
  assign s_axi_awready = !r.aw_full;
  assign s_axi_wready = !r.w_full;
  assign s_axi_arready = !r.rpend && !r.rvalid && !busy;
  assign aw_hs = s_axi_awvalid && s_axi_awready;
  assign w_hs = s_axi_wvalid && s_axi_wready;
  assign ar_hs = s_axi_arvalid && s_axi_arready;
  assign wr_fire = r.aw_full && r.w_full && !r.bvalid && !busy;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rresp = r.rresp;
  assign s_axi_rdata = r.rdata;

  assign status_word = {27'h0, r.linked, r.illegal, r.taken, r.done, busy};

  bcu_decide u_decide (
    .opcode(opcode),
    .mask(field_one),
    .flags(r.flags),
    .offset(field_two),
    .instruction_pointer(r.instruction_pointer),
    .reg_value(rf_rdata),
    .storage_addr(r.storage_addr),
    .long_rx(r.long_rx),
    .known(dec_known),
    .hit(dec_hit),
    .taken(dec_taken),
    .link(dec_link),
    .target(dec_target),
    .next_seq(dec_next_seq)
  );

  bcu_regfile #(
    .DEPTH(BCU_GPR_COUNT),
    .WIDTH(BCU_DATA_W)
  ) u_regfile (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(rf_we),
    .waddr(rf_waddr),
    .wdata(rf_wdata),
    .raddr(rf_raddr),
    .rdata(rf_rdata)
  );

  always_comb begin
    next_r = r;
    rf_we = 1'b0;
    rf_waddr = r.awaddr[2 +: BCU_GPR_IDX_W];
    rf_wdata = r.wdata;
    rf_raddr = (r.st == BCU_FETCH) ? field_two : s_axi_araddr[2 +: BCU_GPR_IDX_W]; // [RL6]
    if (aw_hs) begin
      next_r.aw_full = 1'b1;
      next_r.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      next_r.w_full = 1'b1;
      next_r.wdata = s_axi_wdata;
      next_r.wstrb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    if (wr_fire) begin
      next_r.aw_full = 1'b0;
      next_r.w_full = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = BCU_RESP_OKAY;
      if (is_gpr(r.awaddr)) begin
        rf_we = 1'b1;
        // General registers take whole words: byte strobes would need a second read port here.
        rf_wdata = r.wdata;
      end else begin
        case (r.awaddr)
          BCU_OFF_CTRL: begin
            if (r.wstrb[0]) begin
              next_r.long_rx = r.wdata[BCU_CTRL_LONG_RX];
              if (r.wdata[BCU_CTRL_GO]) begin
                next_r.st = BCU_FETCH;
                next_r.done = 1'b0;
                next_r.taken = 1'b0;
                next_r.illegal = 1'b0;
                next_r.linked = 1'b0;
              end
            end
          end
          BCU_OFF_INSTR: next_r.instr = merge(r.instr, r.wdata, r.wstrb);
          BCU_OFF_LOC: next_r.instruction_pointer = merge(r.instruction_pointer, r.wdata, r.wstrb);
          BCU_OFF_FLAGS: begin
            // Only software writes the flags; no branch path assigns them.
            if (r.wstrb[0]) begin
              next_r.flags = r.wdata[3:0]; // [RL12]
            end
          end
          BCU_OFF_STORAGE: next_r.storage_addr = merge(r.storage_addr, r.wdata, r.wstrb);
          BCU_OFF_STATUS, BCU_OFF_TARGET: next_r.bresp = BCU_RESP_OKAY;
          default: next_r.bresp = BCU_RESP_SLVERR;
        endcase
      end
    end
    if (ar_hs) begin
      next_r.rpend = 1'b1;
      next_r.araddr = s_axi_araddr;
    end
    if (r.rpend) begin
      next_r.rpend = 1'b0;
      next_r.rvalid = 1'b1;
      next_r.rresp = BCU_RESP_OKAY;
      if (is_gpr(r.araddr)) begin
        next_r.rdata = rf_rdata;
      end else begin
        case (r.araddr)
          BCU_OFF_CTRL: next_r.rdata = {30'h0, r.long_rx, 1'b0};
          BCU_OFF_STATUS: next_r.rdata = status_word;
          BCU_OFF_INSTR: next_r.rdata = r.instr;
          BCU_OFF_LOC: next_r.rdata = r.instruction_pointer;
          BCU_OFF_FLAGS: next_r.rdata = {28'h0, r.flags};
          BCU_OFF_STORAGE: next_r.rdata = r.storage_addr;
          BCU_OFF_TARGET: next_r.rdata = r.target;
          default: begin
            next_r.rdata = 32'h0;
            next_r.rresp = BCU_RESP_SLVERR;
          end
        endcase
      end
    end else if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    case (r.st)
      BCU_IDLE: next_r.st = next_r.st;
      BCU_FETCH: next_r.st = BCU_EXEC;
      BCU_EXEC: begin
        // The target is taken from the word read in the fetch cycle, before the link write.
        next_r.st = BCU_IDLE;
        next_r.done = 1'b1;
        next_r.target = dec_target; // [RL10]
        next_r.illegal = !dec_known;
        next_r.taken = dec_known && dec_taken;
        next_r.instruction_pointer = (dec_known && dec_taken) ? dec_target : dec_next_seq; // [RL2] [RL3]
        if (dec_link) begin
          rf_we = 1'b1; // [RL9]
          rf_waddr = field_one;
          rf_wdata = dec_next_seq;
          next_r.linked = 1'b1;
        end
      end
      default: next_r.st = BCU_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
      r.st <= BCU_IDLE;
    end else begin
      r <= next_r;
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  bcu_op_t chk_op;
  logic chk_exec;
  assign chk_op = bcu_classify(opcode);
  assign chk_exec = (r.st == BCU_EXEC);

  property p_mask_test;
    chk_exec && chk_op.test == BCU_TEST_TRUE |=> r.taken == $past(dec_hit);
  endproperty
  a_mask_test: assert property (p_mask_test) else $error("true branch ignores masked flags"); // [RL1] [RL11]

  property p_true_target;
    chk_exec && chk_op.test == BCU_TEST_TRUE && dec_hit |=> r.instruction_pointer == $past(dec_target) && r.done;
  endproperty
  a_true_target: assert property (p_true_target) else $error("true branch missed its target"); // [RL2]

  property p_false_branch;
    chk_exec && chk_op.test == BCU_TEST_FALSE |=> r.taken == !$past(dec_hit);
  endproperty
  a_false_branch: assert property (p_false_branch) else $error("false branch decision wrong"); // [RL3]

  property p_true_opcodes;
    chk_exec && (opcode == BCU_OP_TRUE_RX || opcode == BCU_OP_TRUE_RR) |=> !r.illegal;
  endproperty
  a_true_opcodes: assert property (p_true_opcodes) else $error("true opcode flagged illegal"); // [RL4]

  property p_false_fwd;
    chk_exec && opcode == BCU_OP_FALSE_FWD && !dec_hit |=> r.instruction_pointer == $past(r.instruction_pointer) + {27'h0, $past(field_two), 1'b0};
  endproperty
  a_false_fwd: assert property (p_false_fwd) else $error("false forward short target wrong"); // [RL5] [RL7]

  property p_reg_target;
    chk_exec && opcode == BCU_OP_TRUE_RR && dec_hit |=> r.instruction_pointer == $past(rf_rdata);
  endproperty
  a_reg_target: assert property (p_reg_target) else $error("register form target wrong"); // [RL6]

  property p_back_short;
    chk_exec && opcode == BCU_OP_TRUE_BACK && dec_hit |=> r.instruction_pointer == $past(r.instruction_pointer) - {27'h0, $past(field_two), 1'b0};
  endproperty
  a_back_short: assert property (p_back_short) else $error("backward short target wrong"); // [RL7]

  property p_link_write;
    chk_exec && chk_op.test == BCU_TEST_LINK |-> rf_we && rf_waddr == field_one && rf_wdata == dec_next_seq;
  endproperty
  a_link_write: assert property (p_link_write) else $error("link register not written"); // [RL9]

  property p_link_order;
    r.st == BCU_FETCH && opcode == BCU_OP_LINK_RR ##1 chk_exec |=> r.instruction_pointer == $past(rf_rdata) && r.linked;
  endproperty
  a_link_order: assert property (p_link_order) else $error("link target used updated register"); // [RL10]

  property p_flags_kept;
    r.st == BCU_FETCH |-> ##2 r.flags == $past(r.flags, 2);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("branch changed condition flags"); // [RL12]

endmodule

// ==== design/bcu_pkg.sv ====
// Summary of operation
// RL1 - Register field one of a conditional branch is a 4-bit mask ANDed with the condition code.
// RL2 - Branch-on-true branches when any masked bit is set, else falls through.
// RL3 - Branch-on-false branches only when every masked bit is clear.
// RL4 - Branch-on-true opcodes: 42 indexed, 02 register, 20 backward short, 21 forward short.
// RL5 - Branch-on-false opcodes: 43 indexed, 03 register, 22 backward short, 23 forward short.
// RL6 - Register form takes its target from the register named by field two.
// RL7 - Short form adds or subtracts the halfword offset to the instruction pointer.
// RL8 - Programs supply register and indexed targets on a halfword boundary.
// RL9 - Branch-and-link writes the next sequential address into register field one, then branches.
// RL10 - The link target is computed before the link register is written.
// RL11 - Mask bits align with flags carry, overflow, greater, less from high to low.
// RL12 - No branch instruction changes the condition flags.
package bcu_pkg;

  localparam int BCU_DATA_W = 32;
  localparam int BCU_ADDR_W = 8;
  localparam int BCU_GPR_COUNT = 16;
  localparam int BCU_GPR_IDX_W = 4;

  // Register byte offsets on the AXI4-Lite slave.
  localparam logic [7:0] BCU_OFF_CTRL = 8'h00;
  localparam logic [7:0] BCU_OFF_STATUS = 8'h04;
  localparam logic [7:0] BCU_OFF_INSTR = 8'h08;
  localparam logic [7:0] BCU_OFF_LOC = 8'h0C;
  localparam logic [7:0] BCU_OFF_FLAGS = 8'h10;
  localparam logic [7:0] BCU_OFF_STORAGE = 8'h14;
  localparam logic [7:0] BCU_OFF_TARGET = 8'h18;
  localparam logic [1:0] BCU_GPR_REGION = 2'h1;

  // Field positions.
  localparam int BCU_CTRL_GO = 0;
  localparam int BCU_CTRL_LONG_RX = 1;
  localparam int BCU_ST_BUSY = 0;
  localparam int BCU_ST_DONE = 1;
  localparam int BCU_ST_TAKEN = 2;
  localparam int BCU_ST_ILLEGAL = 3;
  localparam int BCU_ST_LINKED = 4;
  localparam int BCU_INSTR_OP_LSB = 24;
  localparam int BCU_INSTR_R1_LSB = 20;
  localparam int BCU_INSTR_R2_LSB = 16;

  localparam logic [1:0] BCU_RESP_OKAY = 2'h0;
  localparam logic [1:0] BCU_RESP_SLVERR = 2'h2;

  // Instruction lengths in bytes.
  localparam logic [31:0] BCU_LEN_HALF = 32'h2;
  localparam logic [31:0] BCU_LEN_RX = 32'h4;
  localparam logic [31:0] BCU_LEN_RX_LONG = 32'h6;

  localparam logic [7:0] BCU_OP_TRUE_RX = 8'h42;
  localparam logic [7:0] BCU_OP_TRUE_RR = 8'h02;
  localparam logic [7:0] BCU_OP_TRUE_BACK = 8'h20;
  localparam logic [7:0] BCU_OP_TRUE_FWD = 8'h21;
  localparam logic [7:0] BCU_OP_FALSE_RX = 8'h43;
  localparam logic [7:0] BCU_OP_FALSE_RR = 8'h03;
  localparam logic [7:0] BCU_OP_FALSE_BACK = 8'h22;
  localparam logic [7:0] BCU_OP_FALSE_FWD = 8'h23;
  localparam logic [7:0] BCU_OP_LINK_RX = 8'h41;
  localparam logic [7:0] BCU_OP_LINK_RR = 8'h01;

  typedef enum logic [2:0] {BCU_IDLE = 3'h1, BCU_FETCH = 3'h2, BCU_EXEC = 3'h4} bcu_state_t;
  typedef enum logic [1:0] {BCU_TEST_NONE, BCU_TEST_TRUE, BCU_TEST_FALSE, BCU_TEST_LINK} bcu_test_t;
  typedef enum logic [1:0] {BCU_FORM_RX, BCU_FORM_RR, BCU_FORM_BACK, BCU_FORM_FWD} bcu_form_t;
  typedef struct packed {
    bcu_test_t test;
    bcu_form_t form;
  } bcu_op_t;

  function automatic bcu_op_t bcu_classify(input logic [7:0] opcode);
    bcu_op_t op;
    op = '{BCU_TEST_NONE, BCU_FORM_RX};
    case (opcode) // [RL4] [RL5]
      BCU_OP_TRUE_RX: op = '{BCU_TEST_TRUE, BCU_FORM_RX};
      BCU_OP_TRUE_RR: op = '{BCU_TEST_TRUE, BCU_FORM_RR};
      BCU_OP_TRUE_BACK: op = '{BCU_TEST_TRUE, BCU_FORM_BACK};
      BCU_OP_TRUE_FWD: op = '{BCU_TEST_TRUE, BCU_FORM_FWD};
      BCU_OP_FALSE_RX: op = '{BCU_TEST_FALSE, BCU_FORM_RX};
      BCU_OP_FALSE_RR: op = '{BCU_TEST_FALSE, BCU_FORM_RR};
      BCU_OP_FALSE_BACK: op = '{BCU_TEST_FALSE, BCU_FORM_BACK};
      BCU_OP_FALSE_FWD: op = '{BCU_TEST_FALSE, BCU_FORM_FWD};
      BCU_OP_LINK_RX: op = '{BCU_TEST_LINK, BCU_FORM_RX};
      BCU_OP_LINK_RR: op = '{BCU_TEST_LINK, BCU_FORM_RR};
      default: op = '{BCU_TEST_NONE, BCU_FORM_RX};
    endcase
    return op;
  endfunction

endpackage

// ==== design/bcu_regfile.sv ====
`timescale 1ns/1ps
module bcu_regfile import bcu_pkg::*; #(
  parameter int DEPTH = BCU_GPR_COUNT,
  parameter int WIDTH = BCU_DATA_W
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [BCU_GPR_IDX_W-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  input wire logic [BCU_GPR_IDX_W-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);
  if (DEPTH != (1 << BCU_GPR_IDX_W) || WIDTH < 1) begin : g_bad
    $error("bcu_regfile: DEPTH must match the register index width");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [WIDTH-1:0] rdata;
  } bcu_rf_t;

  bcu_rf_t r;
  bcu_rf_t next_r;

  // The read returns the old word when it meets a write to the same entry.
  always_comb begin
    next_r = r;
    next_r.rdata = r.mem[raddr];
    if (we) begin
      next_r.mem[waddr] = wdata;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign rdata = r.rdata;
endmodule

// ==== design/bcu_decide.sv ====
`timescale 1ns/1ps
module bcu_decide import bcu_pkg::*; (
  input wire logic [7:0] opcode,
  input wire logic [3:0] mask,
  input wire logic [3:0] flags,
  input wire logic [3:0] offset,
  input wire logic [31:0] instruction_pointer,
  input wire logic [31:0] reg_value,
  input wire logic [31:0] storage_addr,
  input wire logic long_rx,
  output logic known,
  output logic hit,
  output logic taken,
  output logic link,
  output logic [31:0] target,
  output logic [31:0] next_seq
);
  bcu_op_t op;
  logic [31:0] byte_offset;

  always_comb begin
    op = bcu_classify(opcode);
    // Mask bit 3 meets carry and bit 0 meets less, so a plain AND lines them up.
    hit = |(mask & flags); // [RL1] [RL11]
    known = (op.test != BCU_TEST_NONE);
    link = (op.test == BCU_TEST_LINK);
    case (op.test)
      BCU_TEST_TRUE: taken = hit; // [RL2]
      BCU_TEST_FALSE: taken = !hit; // [RL3]
      BCU_TEST_LINK: taken = 1'b1;
      default: taken = 1'b0;
    endcase
    byte_offset = {27'h0, offset, 1'b0};
    case (op.form)
      BCU_FORM_RR: target = reg_value; // [RL6]
      BCU_FORM_BACK: target = instruction_pointer - byte_offset; // [RL7]
      BCU_FORM_FWD: target = instruction_pointer + byte_offset; // [RL7]
      default: target = storage_addr;
    endcase
    // Odd targets are passed on as given; programs keep them halfword aligned.
    case (op.form)
      BCU_FORM_RX: next_seq = instruction_pointer + (long_rx ? BCU_LEN_RX_LONG : BCU_LEN_RX);
      default: next_seq = instruction_pointer + BCU_LEN_HALF;
    endcase
  end
endmodule

// ==== bench/bcu_seq_model.sv ====
`timescale 1ns/1ps
// Sequencer side of the register bus. It holds each request until its own ready and waits as long as the
// slave needs; only the bench timeout ends a wait.
module bcu_seq_model import bcu_pkg::*; (
  input wire logic aclk,
  output logic [BCU_ADDR_W-1:0] awaddr,
  output logic [2:0] awprot,
  output logic awvalid,
  input wire logic awready,
  output logic [BCU_DATA_W-1:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [BCU_ADDR_W-1:0] araddr,
  output logic [2:0] arprot,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    awaddr = 8'h00;
    awprot = 3'h0;
    awvalid = 1'h0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'h0;
    bready = 1'h0;
    araddr = 8'h00;
    arprot = 3'h0;
    arvalid = 1'h0;
    rready = 1'h0;
  end

  task automatic wr(input logic [BCU_ADDR_W-1:0] a, input logic [BCU_DATA_W-1:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bvalid && bready) begin
        bready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic rd(input logic [BCU_ADDR_W-1:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rvalid && rready) begin
        rready <= 1'h0;
        break;
      end
    end
  endtask
endmodule

// ==== bench/test_conditional_branch_unit.sv ====
`timescale 1ns/1ps
module test_conditional_branch_unit import bcu_pkg::*; ;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [7:0] awaddr, araddr;
  logic [2:0] awprot, arprot;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready, busy;
  logic [33:0] exp_q[$];
  logic [1:0] exp_b[$];
  logic [15:0] lfsr = 16'h5AE0;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  // Each entry is a decision-table row: condition flags in the high nibble, mask in the low nibble.
  localparam logic [7:0] ROWS [7] = '{8'h02, 8'h1A, 8'h98, 8'h44, 8'hA2, 8'h23, 8'h20};
  localparam logic [7:0] OPS [11] = '{BCU_OP_TRUE_RX, BCU_OP_TRUE_RR, BCU_OP_TRUE_BACK, BCU_OP_TRUE_FWD,
    BCU_OP_FALSE_RX, BCU_OP_FALSE_RR, BCU_OP_FALSE_BACK, BCU_OP_FALSE_FWD, BCU_OP_LINK_RX, BCU_OP_LINK_RR, 8'hFF};

  always #12.5 aclk = ~aclk;

  bcu_top u_bcu_top (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(awprot), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(arprot), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .busy(busy));

  bcu_seq_model u_bcu_seq_model (.aclk(aclk), .awaddr(awaddr), .awprot(awprot), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid), .arready(arready),
    .rvalid(rvalid), .rready(rready));

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic check(input logic [33:0] seen, input logic [33:0] want);
    tests_run++;
    if (seen !== want) begin
      fails++;
      $display("FAIL t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask

  // The watcher pairs every read answer with the oldest note, so reads must complete in issue order.
  always @(posedge aclk) begin
    if (rvalid && rready) begin
      if (exp_q.size() > 0) begin
        check({rresp, rdata}, exp_q.pop_front());
      end else begin
        check({rresp, rdata}, 34'h0);
        fails++;
      end
    end
  end

  always @(posedge aclk) begin
    if (bvalid && bready) begin
      if (exp_b.size() > 0) begin
        check({32'h0, bresp}, {32'h0, exp_b.pop_front()});
      end else begin
        check({32'h0, bresp}, 34'h0);
        fails++;
      end
    end
  end

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      tally_and_finish();
    end
  end

  function automatic logic [31:0] rnd();
    logic [31:0] v;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    v[31:16] = lfsr;
    lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
    v[15:0] = lfsr;
    return v;
  endfunction

  task automatic rd_exp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_q.push_back({r, d});
    u_bcu_seq_model.rd(a);
  endtask

  task automatic wr_exp(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    exp_b.push_back(r);
    u_bcu_seq_model.wr(a, d);
  endtask

  task automatic run_case(input logic [7:0] op, input logic [3:0] m, input logic [3:0] f, input logic [3:0] n,
                          input logic lng);
    logic [31:0] instruction_pointer, st, rv, nseq, tgt;
    logic hit, tk, lk, ill;
    logic [3:0] nbusy;
    instruction_pointer = rnd() & 32'hFFFFFFFE;
    st = rnd() & 32'hFFFFFFFE;
    rv = rnd() & 32'hFFFFFFFE;
    hit = |(m & f);
    lk = 1'h0;
    ill = 1'h0;
    // An undefined opcode is stepped over like an indexed instruction.
    case (op)
      BCU_OP_TRUE_RR, BCU_OP_FALSE_RR, BCU_OP_LINK_RR, BCU_OP_TRUE_BACK, BCU_OP_TRUE_FWD, BCU_OP_FALSE_BACK,
        BCU_OP_FALSE_FWD: nseq = instruction_pointer + BCU_LEN_HALF;
      default: nseq = instruction_pointer + (lng ? BCU_LEN_RX_LONG : BCU_LEN_RX);
    endcase
    case (op)
      BCU_OP_TRUE_BACK, BCU_OP_FALSE_BACK: tgt = instruction_pointer - {27'h0, n, 1'h0};
      BCU_OP_TRUE_FWD, BCU_OP_FALSE_FWD: tgt = instruction_pointer + {27'h0, n, 1'h0};
      BCU_OP_TRUE_RR, BCU_OP_FALSE_RR, BCU_OP_LINK_RR: tgt = rv;
      default: tgt = st;
    endcase
    case (op)
      BCU_OP_TRUE_RX, BCU_OP_TRUE_RR, BCU_OP_TRUE_BACK, BCU_OP_TRUE_FWD: tk = hit;
      BCU_OP_FALSE_RX, BCU_OP_FALSE_RR, BCU_OP_FALSE_BACK, BCU_OP_FALSE_FWD: tk = !hit;
      BCU_OP_LINK_RX, BCU_OP_LINK_RR: begin
        tk = 1'h1;
        lk = 1'h1;
      end
      default: begin
        tk = 1'h0;
        ill = 1'h1;
      end
    endcase
    wr_exp(BCU_OFF_FLAGS, {28'h0, f}, BCU_RESP_OKAY);
    wr_exp(BCU_OFF_LOC, instruction_pointer, BCU_RESP_OKAY);
    wr_exp(BCU_OFF_STORAGE, st, BCU_RESP_OKAY);
    wr_exp({2'h1, n, 2'h0}, rv, BCU_RESP_OKAY);
    wr_exp(BCU_OFF_INSTR, {op, m, n, 16'h0}, BCU_RESP_OKAY);
    wr_exp(BCU_OFF_CTRL, {30'h0, lng, 1'h1}, BCU_RESP_OKAY);
    // The fetch cycle reads the target register and the execute cycle writes the link, so two busy cycles.
    nbusy = 4'h0;
    while (busy !== 1'h0) begin
      nbusy++;
      @(posedge aclk);
    end
    check({30'h0, nbusy}, 34'h2);
    rd_exp(BCU_OFF_LOC, tk ? tgt : nseq, BCU_RESP_OKAY);
    rd_exp(BCU_OFF_STATUS, {27'h0, lk, ill, tk, 1'h1, 1'h0}, BCU_RESP_OKAY);
    rd_exp(BCU_OFF_FLAGS, {28'h0, f}, BCU_RESP_OKAY);
    if (lk) rd_exp({2'h1, m, 2'h0}, nseq, BCU_RESP_OKAY);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (ROWS[i]) begin
      run_case(BCU_OP_TRUE_FWD, ROWS[i][3:0], ROWS[i][7:4], 4'hF, 1'h0);
      run_case(BCU_OP_FALSE_BACK, ROWS[i][3:0], ROWS[i][7:4], 4'h3, 1'h0);
    end
    repeat (3) begin
      foreach (OPS[i]) begin
        run_case(OPS[i], 4'(rnd()), 4'(rnd()), 4'(rnd()), 1'(rnd()));
      end
    end
    // The link register doubling as the target register must still branch to its old contents.
    run_case(BCU_OP_LINK_RR, 4'h5, 4'h0, 4'h5, 1'h0);
    run_case(BCU_OP_LINK_RX, 4'h3, 4'hF, 4'h0, 1'h1);
    run_case(BCU_OP_TRUE_BACK, 4'h8, 4'h9, 4'h7, 1'h0);
    run_case(BCU_OP_FALSE_FWD, 4'h2, 4'h0, 4'h9, 1'h0);
    run_case(BCU_OP_TRUE_RR, 4'h3, 4'h2, 4'hA, 1'h0);
    wr_exp(BCU_OFF_STATUS, 32'h1F, BCU_RESP_OKAY);
    wr_exp(8'h20, 32'h0, BCU_RESP_SLVERR);
    rd_exp(8'h20, 32'h0, BCU_RESP_SLVERR);
    @(posedge aclk);
    @(posedge aclk);
    tally_and_finish();
  end
endmodule
